// *** core/csf_defines.svh ***
// register offsets, field positions and reset values of the status flag block
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_ADDR_W        4
`define CSF_OFF_EVENT     4'h0
`define CSF_OFF_STATUS    4'h4
`define CSF_OFF_IRQ_STAT  4'h8
`define CSF_OFF_IRQ_MASK  4'hC
`define CSF_BIT_BUS_OFF   0
`define CSF_BIT_WARN      1
`define CSF_BIT_TX        0
`define CSF_BIT_RX        1
`define CSF_BIT_RESET     2
`define CSF_BIT_HALT      3
`define CSF_BIT_SLEEP     4
`define CSF_BIT_PASSIVE   5
`define CSF_BUS_OFF_LIMIT 9'h100
`define CSF_WARN_LIMIT    9'h060
`define CSF_STATUS_RST    6'h14
`define CSF_IRQ_W         2
`endif

// *** core/csf_pkg.sv ***
// types of the status flag block
package csf_pkg;
	typedef enum logic [1:0] {
		CSF_BUS_IDLE = 2'b00,
		CSF_BUS_TX   = 2'b01,
		CSF_BUS_RX   = 2'b10
	} csf_bus_t;
	typedef enum logic [1:0] {
		CSF_MODE_OP    = 2'b00,
		CSF_MODE_RESET = 2'b01,
		CSF_MODE_HALT  = 2'b10,
		CSF_MODE_SLEEP = 2'b11
	} csf_mode_t;
endpackage

// *** core/csf_status_flags.sv ***
// status and error-state flag logic of a can controller
`timescale 1ns/1ps
`include "csf_defines.svh"

module csf_status_flags
	import csf_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic [8:0]             tx_err_count,
	input  wire logic [7:0]             rx_err_count,
	input  wire csf_bus_t               bus_activity,
	input  wire csf_mode_t              ctrl_mode,
	input  wire logic                   error_passive,
	input  wire logic [`CSF_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	output logic                        bus_off_entry_flag,
	output logic                        error_warning_flag,
	output logic                        transmitter_status_flag,
	output logic                        receiver_status_flag,
	output logic                        reset_mode_status_flag,
	output logic                        halt_mode_status_flag,
	output logic                        sleep_mode_status_flag,
	output logic                        error_passive_status_flag,
	output logic                        irq
);

	logic                 bus_off_q;
	logic                 warn_q;
	logic                 tx_q;
	logic                 rx_q;
	logic                 rstm_q;
	logic                 halt_q;
	logic                 sleep_q;
	logic                 passive_q;
	logic                 bus_off_now;
	logic                 warn_now;
	logic                 bus_off_rise;
	logic                 warn_rise;
	logic                 wr_event;
	logic                 rd_irq_stat;
	logic [`CSF_IRQ_W-1:0] irq_stat_q;
	logic [`CSF_IRQ_W-1:0] irq_mask_q;
	logic [`CSF_IRQ_W-1:0] irq_set;
	logic [5:0]           status_vec;

	function automatic logic reg_hit(input logic [`CSF_ADDR_W-1:0] a,
		input logic [`CSF_ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	assign bus_off_now  = (tx_err_count >= `CSF_BUS_OFF_LIMIT);
	assign warn_now     = (tx_err_count >= `CSF_WARN_LIMIT)
		|| ({1'b0, rx_err_count} >= `CSF_WARN_LIMIT);
	assign bus_off_rise = bus_off_now && !bus_off_q;
	assign warn_rise    = warn_now && !warn_q;
	assign wr_event     = reg_wr && reg_hit(reg_addr, `CSF_OFF_EVENT);
	assign rd_irq_stat  = reg_rd && reg_hit(reg_addr, `CSF_OFF_IRQ_STAT);
	assign irq_set      = {warn_rise, bus_off_rise};

	// sticky bus-off flag; a fresh entry in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_off_q <= 1'b0;
		end else if (bus_off_now) begin
			bus_off_q <= 1'b1;
		end else if (wr_event && !reg_wdata[`CSF_BIT_BUS_OFF]) begin
			bus_off_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			warn_q    <= 1'b0;
			passive_q <= 1'b0;
		end else begin
			warn_q    <= warn_now;
			passive_q <= error_passive;
		end
	end

	// bus activity: bus-off forces the transmitter flag
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_q <= 1'b0;
			rx_q <= 1'b0;
		end else begin
			tx_q <= (bus_activity == CSF_BUS_TX) || bus_off_now;
			rx_q <= (bus_activity == CSF_BUS_RX) && !bus_off_now;
		end
	end

	// operating modes; hardware reset lands in reset and sleep modes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rstm_q  <= 1'b1;
			halt_q  <= 1'b0;
			sleep_q <= 1'b1;
		end else begin
			rstm_q  <= (ctrl_mode == CSF_MODE_RESET);
			halt_q  <= (ctrl_mode == CSF_MODE_HALT);
			sleep_q <= (ctrl_mode == CSF_MODE_SLEEP);
		end
	end

	// interrupt status: set wins over read-clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_stat_q <= '0;
		end else if (rd_irq_stat) begin
			irq_stat_q <= irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_mask_q <= '0;
		end else if (reg_wr && reg_hit(reg_addr, `CSF_OFF_IRQ_MASK)) begin
			irq_mask_q <= reg_wdata[`CSF_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_stat_q | irq_set) & irq_mask_q
				& ~(rd_irq_stat ? irq_stat_q & ~irq_set : '0));
		end
	end

	assign status_vec = {passive_q, sleep_q, halt_q, rstm_q, rx_q, tx_q};

	// status register is read-only; writes there are ignored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`CSF_OFF_EVENT:    reg_rdata <= {30'h0, warn_q, bus_off_q};
				`CSF_OFF_STATUS:   reg_rdata <= {26'h0, status_vec};
				`CSF_OFF_IRQ_STAT: reg_rdata <= {30'h0, irq_stat_q};
				`CSF_OFF_IRQ_MASK: reg_rdata <= {30'h0, irq_mask_q};
				default:           reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_off_entry_flag        <= 1'b0;
			error_warning_flag        <= 1'b0;
			transmitter_status_flag   <= 1'b0;
			receiver_status_flag      <= 1'b0;
			reset_mode_status_flag    <= 1'b1;
			halt_mode_status_flag     <= 1'b0;
			sleep_mode_status_flag    <= 1'b1;
			error_passive_status_flag <= 1'b0;
		end else begin
			bus_off_entry_flag        <= bus_off_now
				|| (bus_off_q && !(wr_event && !reg_wdata[`CSF_BIT_BUS_OFF]));
			error_warning_flag        <= warn_now;
			transmitter_status_flag   <= (bus_activity == CSF_BUS_TX) || bus_off_now;
			receiver_status_flag      <= (bus_activity == CSF_BUS_RX) && !bus_off_now;
			reset_mode_status_flag    <= (ctrl_mode == CSF_MODE_RESET);
			halt_mode_status_flag     <= (ctrl_mode == CSF_MODE_HALT);
			sleep_mode_status_flag    <= (ctrl_mode == CSF_MODE_SLEEP);
			error_passive_status_flag <= error_passive;
		end
	end

endmodule

// *** tb/csf_can_node.sv ***
// far-side node model: puts the requested activity on the bus a cycle later
`timescale 1ns/1ps
module csf_can_node
	import csf_pkg::*;
(
	input  wire logic     clk,
	input  wire csf_bus_t want,
	output csf_bus_t      bus_activity
);
	initial bus_activity = CSF_BUS_IDLE;
	always @(posedge clk) begin
		bus_activity <= want;
	end
endmodule

// *** tb/csf_status_flags_monitor.sv ***
// assertions on the status flag ports
`timescale 1ns/1ps
module csf_mon
	import csf_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic [8:0] tx_err_count,
	input wire logic [7:0] rx_err_count,
	input wire csf_bus_t   bus_activity,
	input wire csf_mode_t  ctrl_mode,
	input wire logic       error_passive,
	input wire logic       bus_off_entry_flag,
	input wire logic       error_warning_flag,
	input wire logic       transmitter_status_flag,
	input wire logic       receiver_status_flag,
	input wire logic       reset_mode_status_flag,
	input wire logic       halt_mode_status_flag,
	input wire logic       sleep_mode_status_flag,
	input wire logic       error_passive_status_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic bo = tx_err_count[8];
	a_bus_off_set: assert property (bo |=> bus_off_entry_flag) else $error("bus-off");
	a_warn_level: assert property ((tx_err_count >= 9'h060 || rx_err_count >= 8'h60)
		|=> error_warning_flag) else $error("warn");
	a_tx_flag: assert property ((bo || bus_activity == CSF_BUS_TX)
		|=> transmitter_status_flag) else $error("tx");
	a_rx_only: assert property ((bo || bus_activity != CSF_BUS_RX)
		|=> !receiver_status_flag) else $error("rx");
	a_idle_both: assert property ((!bo && bus_activity == CSF_BUS_IDLE)
		|=> !(transmitter_status_flag || receiver_status_flag)) else $error("idle");
	a_reset_mode: assert property (ctrl_mode == CSF_MODE_RESET
		|=> reset_mode_status_flag && !sleep_mode_status_flag) else $error("reset");
	a_halt_mode: assert property (ctrl_mode != CSF_MODE_HALT
		|=> !halt_mode_status_flag) else $error("halt");
	a_sleep_mode: assert property (ctrl_mode == CSF_MODE_SLEEP
		|=> sleep_mode_status_flag && !halt_mode_status_flag) else $error("sleep");
	a_passive_flag: assert property (error_passive |=> error_passive_status_flag) else $error("ep");
endmodule
bind csf_status_flags csf_mon u_mon (.*);

// *** tb/test_can_status_flag_logic.sv ***
// self-checking bench of the status flag block
`timescale 1ns/1ps
module test_can_status_flag_logic
	import csf_pkg::*;
;
	logic        clk, rst_b, error_passive, reg_wr, reg_rd, irq;
	logic [8:0]  tx_err_count;
	logic [7:0]  rx_err_count, st;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	csf_bus_t    want, bus_activity;
	csf_mode_t   ctrl_mode;
	int          n_mismatch, check_count, cyc;
	csf_can_node node (.clk(clk), .want(want), .bus_activity(bus_activity));
	csf_status_flags uut (.*, .bus_off_entry_flag(st[7]), .error_warning_flag(st[6]),
		.error_passive_status_flag(st[5]), .sleep_mode_status_flag(st[4]),
		.halt_mode_status_flag(st[3]), .reset_mode_status_flag(st[2]),
		.receiver_status_flag(st[1]), .transmitter_status_flag(st[0]));
	task automatic close_out();
		if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask
	task automatic fl(input logic [7:0] e);
		repeat (2) @(posedge clk);
		#1 chk(st, e);
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		{rst_b, error_passive, reg_wr, reg_rd, tx_err_count, rx_err_count} = '0;
		{reg_addr, reg_wdata} = '0;
		want = CSF_BUS_IDLE;
		ctrl_mode = CSF_MODE_SLEEP;
		repeat (14) @(posedge clk);
		fl(8'h14);
		rst_b <= 1'b1;
		rd(4'h4, 32'h10);
		for (int i = 3; i >= 0; i--) begin
			ctrl_mode <= csf_mode_t'(i);
			fl({3'h0, i == 3, i == 2, i == 1, 2'h0});
		end
		error_passive <= 1'b1;
		fl(8'h20);
		error_passive <= 1'b0;
		want <= CSF_BUS_TX;
		fl(8'h01);
		want <= CSF_BUS_RX;
		fl(8'h02);
		want <= CSF_BUS_IDLE;
		{tx_err_count, rx_err_count} <= {9'h05F, 8'h5F};
		fl(8'h00);
		rx_err_count <= 8'h60;
		fl(8'h40);
		{tx_err_count, rx_err_count} <= {9'h060, 8'h00};
		fl(8'h40);
		rd(4'h8, 32'h2);
		wr(4'hC, 32'h3);
		want <= CSF_BUS_RX;
		tx_err_count <= 9'h0FF;
		fl(8'h42);
		tx_err_count <= 9'h100;
		fl(8'hC1);
		chk(irq, 1'b1);
		rd(4'h8, 32'h1);
		fl(8'hC1);
		chk(irq, 1'b0);
		tx_err_count <= 9'h000;
		fl(8'h82);
		wr(4'h4, 32'h3F);
		wr(4'h0, 32'h0);
		fl(8'h02);
		rd(4'h0, 32'h0);
		rd(4'h2, 32'h0);
		close_out();
	end
endmodule
